// [logic/tmrs_defines.vh]
// Constants for the target mode and reset sequencer.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef TMRS_DEFINES_VH
`define TMRS_DEFINES_VH

// System clock rate in Hz.
`define CLK_HZ 50000000
// Reset pulse on restart, in milliseconds.
`define RST_PULSE_MS 100
// Reset release gap on serial program-mode restart, in milliseconds.
`define REL_GAP_MS 3
// Time allowed for the target to answer an exchange, in microseconds.
`define ANSWER_WAIT_US 50

// Link selection codes.
`define LINK_SERIAL 2'h0
`define LINK_TWOWIRE 2'h1
`define LINK_ONEWIRE 2'h2

// Command codes.
`define CMD_SET_RUN 3'h0
`define CMD_SET_PROG 3'h1
`define CMD_RESTART 3'h2
`define CMD_PRESENT 3'h3
`define CMD_MAP_WRITE 3'h4
`define CMD_MAP_READ 3'h5
`define CMD_CLEAR_LAYOUT 3'h6
`define CMD_ERASE 3'h7

// Memory types.
`define MEM_FLASH 2'h0
`define MEM_RAM 2'h1
`define MEM_EEPROM 2'h2

// Memory map properties.
`define PROP_BASE 2'h0
`define PROP_SIZE 2'h1
`define PROP_PAGE 2'h2

// Reset value of each map entry.
`define MAP_RESET 32'h0000_0000

`endif

// [logic/pin_sync3.v]
// Three-stage synchroniser for one input pin.
// Assumes the pin is asynchronous to i_sys_clk; output follows once stages two and three agree.
`default_nettype none

module pin_sync3 (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_pin,
  output reg o_level
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // The first stage feeds only the second stage; the output updates on agreement.
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

// [logic/target_mode_reset_sequencer.v]
// Mode, restart and memory-map sequencer for an attached target controller.
// Assumes commands arrive as a one-cycle strobe on i_sys_clk and the answer pin is asynchronous.
//
// Function
// RL1 - Serial and one-wire program entry: enable programming, hold target reset.
// RL2 - Serial and one-wire run entry: leave programming, release reset, target runs.
// RL3 - Two-wire program entry leaves run state alone, only sets up the link.
// RL4 - Two-wire run entry stops link clock first, then ends programming.
// RL5 - One-wire target left programming stays halted until power is cycled.
// RL6 - Restart cycles reset then returns to the previous run or program mode.
// RL7 - Run-mode restart on serial or two-wire holds reset 100 ms.
// RL8 - Serial program-mode restart releases reset 3 ms, then re-enters programming.
// RL9 - Two-wire program restart: drop link, reset 100 ms, relink, restore.
// RL10 - Two-wire link never holds the target in reset while operating.
// RL11 - Restart on the one-wire link is refused.
// RL12 - Settable, readable base, size and page map for flash, RAM, EEPROM.
// RL13 - Property not applying to the memory type gives unsupported error.
// RL14 - Reading an undetermined property gives undetermined value error.
// RL15 - Clearing memory layout needs program mode, else wrong mode error.
// RL16 - Flash erase needs program mode; EEPROM erased unless keep fuse set.
// RL17 - Failed exchange with target reports link failure error.
// RL18 - Controller restarts only when brief firmware run is harmless.
// RL19 - Presence query reports 1 or 0 and keeps the operating mode.
// RL20 - Target reset is active low and released after programmer reset.
`include "tmrs_defines.vh"
`default_nettype none

module target_mode_reset_sequencer #(
  parameter [31:0] RST_PULSE_CYC = `RST_PULSE_MS * (`CLK_HZ / 1000),
  parameter [31:0] REL_GAP_CYC = `REL_GAP_MS * (`CLK_HZ / 1000),
  parameter [31:0] ANSWER_CYC = `ANSWER_WAIT_US * (`CLK_HZ / 1000000)
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire [1:0] i_link_sel,
  input wire i_cmd_valid,
  input wire [2:0] i_cmd_code,
  input wire [1:0] i_map_mem,
  input wire [1:0] i_map_prop,
  input wire [31:0] i_map_value,
  input wire i_eeprom_keep_fuse,
  input wire i_tgt_answer,
  output reg o_busy,
  output reg o_done,
  output reg o_flash_access_mode,
  output reg o_tgt_reset_n,
  output reg o_prog_enable,
  output reg o_link_active,
  output reg o_link_clk_en,
  output reg o_xfer_req,
  output reg o_erase_req,
  output reg o_erase_eeprom,
  output reg o_present,
  output reg [31:0] o_read_data,
  output reg o_wrong_mode_error,
  output reg o_link_failure_error,
  output reg o_unsupported_combo_error,
  output reg o_undetermined_value_error
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_XFER = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_STOPCLK = 3'h3;
  localparam [2:0] S_DONE = 3'h4;

  // What to do when the timer in S_WAIT runs out.
  localparam [1:0] P_RUN_RELEASE = 2'h0;
  localparam [1:0] P_SERIAL_REENTER = 2'h1;
  localparam [1:0] P_TWOWIRE_RELINK = 2'h2;

  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [31:0] timer_reg;
  reg present_cmd_reg;
  reg [31:0] map_reg [0:8];
  reg [8:0] known_reg;
  wire answer_level;
  wire [3:0] map_idx;
  integer k;

  // A property applies unless it is the page size of RAM or the memory type or property code is unknown.
  function prop_applies;
    input [1:0] mem;
    input [1:0] prop;
    begin
      prop_applies = (mem != 2'h3) && (prop != 2'h3) &&
                     !((mem == `MEM_RAM) && (prop == `PROP_PAGE));
    end
  endfunction

  // Flat index of a map entry: three properties per memory type.
  function [3:0] entry_index;
    input [1:0] mem;
    input [1:0] prop;
    begin
      entry_index = {mem, 1'b0} + {2'h0, mem} + {2'h0, prop};
    end
  endfunction

  assign map_idx = entry_index(i_map_mem, i_map_prop);

  // The answer pin comes from the target and is synchronised.
  pin_sync3 u_answer_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin(i_tgt_answer),
    .o_level(answer_level)
  );

  // Sequencer for mode changes, restarts, exchanges and map commands.
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_reg <= S_IDLE;
      phase_reg <= P_RUN_RELEASE;
      timer_reg <= 32'h0000_0000;
      present_cmd_reg <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_flash_access_mode <= 1'b0;
      // RL20 reset released
      o_tgt_reset_n <= 1'b1;
      o_prog_enable <= 1'b0;
      o_link_active <= 1'b0;
      o_link_clk_en <= 1'b0;
      o_xfer_req <= 1'b0;
      o_erase_req <= 1'b0;
      o_erase_eeprom <= 1'b0;
      o_present <= 1'b0;
      o_read_data <= 32'h0000_0000;
      o_wrong_mode_error <= 1'b0;
      o_link_failure_error <= 1'b0;
      o_unsupported_combo_error <= 1'b0;
      o_undetermined_value_error <= 1'b0;
      known_reg <= 9'h000;
      for (k = 0; k < 9; k = k + 1) begin
        map_reg[k] <= `MAP_RESET;
      end
    end else begin
      o_done <= 1'b0;
      o_xfer_req <= 1'b0;
      o_erase_req <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (i_cmd_valid) begin
            o_busy <= 1'b1;
            o_wrong_mode_error <= 1'b0;
            o_link_failure_error <= 1'b0;
            o_unsupported_combo_error <= 1'b0;
            o_undetermined_value_error <= 1'b0;
            present_cmd_reg <= 1'b0;
            state_reg <= S_DONE;
            case (i_cmd_code)
              `CMD_SET_PROG: begin
                o_flash_access_mode <= 1'b1;
                o_xfer_req <= 1'b1;
                timer_reg <= ANSWER_CYC;
                state_reg <= S_XFER;
                if (i_link_sel == `LINK_TWOWIRE) begin
                  // RL3 link setup only
                  o_link_active <= 1'b1;
                  o_link_clk_en <= 1'b1;
                end else begin
                  // RL1 enable and hold
                  o_prog_enable <= 1'b1;
                  o_tgt_reset_n <= 1'b0;
                end
              end
              `CMD_SET_RUN: begin
                o_flash_access_mode <= 1'b0;
                if (i_link_sel == `LINK_TWOWIRE) begin
                  // RL4 clock stops first
                  o_link_clk_en <= 1'b0;
                  state_reg <= S_STOPCLK;
                end else begin
                  // RL2 leave and release
                  o_prog_enable <= 1'b0;
                  o_tgt_reset_n <= 1'b1;
                end
              end
              `CMD_RESTART: begin
                if (i_link_sel == `LINK_ONEWIRE) begin
                  // RL11 restart refused
                  o_unsupported_combo_error <= 1'b1;
                end else if (!o_flash_access_mode) begin
                  // RL7 run restart pulse
                  o_tgt_reset_n <= 1'b0;
                  timer_reg <= RST_PULSE_CYC;
                  phase_reg <= P_RUN_RELEASE;
                  state_reg <= S_WAIT;
                end else if (i_link_sel == `LINK_SERIAL) begin
                  // RL8 release gap
                  o_tgt_reset_n <= 1'b1;
                  o_prog_enable <= 1'b0;
                  timer_reg <= REL_GAP_CYC;
                  phase_reg <= P_SERIAL_REENTER;
                  state_reg <= S_WAIT;
                end else begin
                  // RL9 drop link, pulse
                  o_link_active <= 1'b0;
                  o_link_clk_en <= 1'b0;
                  o_tgt_reset_n <= 1'b0;
                  timer_reg <= RST_PULSE_CYC;
                  phase_reg <= P_TWOWIRE_RELINK;
                  state_reg <= S_WAIT;
                end
              end
              `CMD_PRESENT: begin
                // RL19 query, mode kept
                present_cmd_reg <= 1'b1;
                o_xfer_req <= 1'b1;
                timer_reg <= ANSWER_CYC;
                state_reg <= S_XFER;
              end
              `CMD_MAP_WRITE: begin
                if (!prop_applies(i_map_mem, i_map_prop)) begin
                  // RL13 combination rejected
                  o_unsupported_combo_error <= 1'b1;
                end else begin
                  // RL12 store property
                  map_reg[map_idx] <= i_map_value;
                  known_reg[map_idx] <= 1'b1;
                end
              end
              `CMD_MAP_READ: begin
                if (!prop_applies(i_map_mem, i_map_prop)) begin
                  // RL13 combination rejected
                  o_unsupported_combo_error <= 1'b1;
                end else if (!known_reg[map_idx]) begin
                  // RL14 value undetermined
                  o_undetermined_value_error <= 1'b1;
                end else begin
                  // RL12 return property
                  o_read_data <= map_reg[map_idx];
                end
              end
              `CMD_CLEAR_LAYOUT: begin
                // RL15 mode checked
                if (!o_flash_access_mode) begin
                  o_wrong_mode_error <= 1'b1;
                end else begin
                  known_reg <= 9'h000;
                end
              end
              `CMD_ERASE: begin
                // RL16 whole flash erase
                if (!o_flash_access_mode) begin
                  o_wrong_mode_error <= 1'b1;
                end else begin
                  o_erase_req <= 1'b1;
                  o_erase_eeprom <= !i_eeprom_keep_fuse;
                  o_xfer_req <= 1'b1;
                  timer_reg <= ANSWER_CYC;
                  state_reg <= S_XFER;
                end
              end
              default: begin
                state_reg <= S_DONE;
              end
            endcase
          end
        end
        S_STOPCLK: begin
          // RL4 then end programming
          o_link_active <= 1'b0;
          o_prog_enable <= 1'b0;
          state_reg <= S_DONE;
        end
        S_WAIT: begin
          if (timer_reg > 32'h0000_0001) begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end else begin
            case (phase_reg)
              P_SERIAL_REENTER: begin
                // RL6 program mode restored
                o_prog_enable <= 1'b1;
                o_tgt_reset_n <= 1'b0;
                o_xfer_req <= 1'b1;
                timer_reg <= ANSWER_CYC;
                state_reg <= S_XFER;
              end
              P_TWOWIRE_RELINK: begin
                // RL10 reset freed in the relink cycle
                o_tgt_reset_n <= 1'b1;
                o_link_active <= 1'b1;
                o_link_clk_en <= 1'b1;
                o_xfer_req <= 1'b1;
                timer_reg <= ANSWER_CYC;
                state_reg <= S_XFER;
              end
              default: begin
                // RL6 run mode kept
                o_tgt_reset_n <= 1'b1;
                state_reg <= S_DONE;
              end
            endcase
          end
        end
        S_XFER: begin
          if (answer_level) begin
            o_present <= present_cmd_reg ? 1'b1 : o_present;
            state_reg <= S_DONE;
          end else if (timer_reg > 32'h0000_0001) begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end else begin
            if (present_cmd_reg) begin
              // RL19 no target found
              o_present <= 1'b0;
            end else begin
              // RL17 exchange failed
              o_link_failure_error <= 1'b1;
            end
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [verif/tgt_model.sv]
// Behavioural target controller on the sequencer's pins.
// Assumes the sequencer clock; the bench picks muting and slow answers.
`default_nettype none
module tgt_model (
  input wire logic i_sys_clk,
  input wire logic i_prog_enable,
  input wire logic i_link_active,
  input wire logic i_mute,
  input wire logic i_slow,
  output logic o_answer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_reg = 8'h00;
  // The target answers while programming or the link is held, and a muted one never does.
  always @(posedge i_sys_clk) begin
    sh_reg <= {sh_reg[6:0], (i_prog_enable | i_link_active) & !i_mute};
  end
  // Slow answers come eight cycles late, still inside the answer window.
  assign o_answer = i_slow ? sh_reg[7] : sh_reg[0];
endmodule
`default_nettype wire

// [verif/tmrs_props_props.sv]
// Port checker for the target mode and reset sequencer.
// Assumes one clock domain with a synchronous active-low reset.
`default_nettype none
module tmrs_props #(
  parameter [31:0] RST_PULSE_CYC = 32'h14,
  parameter [31:0] REL_GAP_CYC = 32'h0A
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_link_sel,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_code,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_flash_access_mode,
  input wire logic o_tgt_reset_n,
  input wire logic o_prog_enable,
  input wire logic o_link_active,
  input wire logic o_link_clk_en,
  input wire logic o_xfer_req,
  input wire logic o_erase_req,
  input wire logic o_wrong_mode_error,
  input wire logic o_unsupported_combo_error
);
  logic [31:0] lo_cnt;
  logic [31:0] hi_cnt;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Count how long the target reset has been low or high.
  always @(posedge i_sys_clk) begin
    lo_cnt <= (!i_rstn || o_tgt_reset_n) ? 32'h0 : lo_cnt + 32'h1;
    hi_cnt <= (!i_rstn || !o_tgt_reset_n) ? 32'h0 : hi_cnt + 32'h1;
  end
  a_prog_entry: assert property ($rose(o_flash_access_mode) && !o_link_active |->
    !o_tgt_reset_n && o_prog_enable) else $error("program entry pins wrong");
  a_run_entry: assert property ($fell(o_flash_access_mode) && !o_link_active |->
    ##[0:1] (o_tgt_reset_n && !o_prog_enable)) else $error("run entry pins wrong");
  a_clock_first: assert property ($fell(o_link_clk_en) && !o_flash_access_mode |->
    o_link_active ##1 !o_link_active) else $error("link dropped before clock stop");
  a_link_no_reset: assert property (o_link_active |-> o_tgt_reset_n)
    else $error("reset held while link active");
  a_run_pulse: assert property ($rose(o_tgt_reset_n) && $past(o_busy) &&
    !o_flash_access_mode |-> lo_cnt >= RST_PULSE_CYC && lo_cnt <= RST_PULSE_CYC + 32'h2)
    else $error("restart reset pulse length wrong");
  a_prog_gap: assert property ($fell(o_tgt_reset_n) && $past(o_busy) &&
    o_flash_access_mode |-> hi_cnt >= REL_GAP_CYC && hi_cnt <= REL_GAP_CYC + 32'h2)
    else $error("restart release gap wrong");
  a_onewire_refuse: assert property (i_cmd_valid && !o_busy && !o_done &&
    i_cmd_code == 3'h2 && i_link_sel == 2'h2 |-> ##[1:3] (o_done && o_unsupported_combo_error))
    else $error("one-wire restart not refused");
  a_erase_mode: assert property (o_erase_req |-> o_flash_access_mode)
    else $error("erase issued in run mode");
  a_erase_exchange: assert property (o_erase_req |-> o_xfer_req)
    else $error("erase issued without exchange");
  a_clear_mode: assert property (o_done && o_wrong_mode_error |-> !o_flash_access_mode)
    else $error("wrong mode flagged in program mode");
endmodule
bind target_mode_reset_sequencer tmrs_props #(.RST_PULSE_CYC(RST_PULSE_CYC),
  .REL_GAP_CYC(REL_GAP_CYC)) u_tmrs_props (.i_sys_clk, .i_rstn, .i_link_sel, .i_cmd_valid,
  .i_cmd_code, .o_busy, .o_done, .o_flash_access_mode, .o_tgt_reset_n, .o_prog_enable,
  .o_link_active, .o_link_clk_en, .o_xfer_req, .o_erase_req, .o_wrong_mode_error,
  .o_unsupported_combo_error);
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the target mode and reset sequencer.
// Assumes the design, the target model and the checker are compiled first.
`include "tmrs_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, valid = 1'b0, fuse = 1'b0, mute = 1'b0, slow = 1'b0;
  logic [1:0] link = 2'h0, mem = 2'h0, prop = 2'h0;
  logic [2:0] code = 3'h0;
  logic [31:0] val = 32'h0;
  wire logic ans, busy, done, mode, rst_n, pe, la, lce, xfer, er, ee, pres, wm, lf, uc, uv;
  wire logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  target_mode_reset_sequencer #(.RST_PULSE_CYC(32'h14), .REL_GAP_CYC(32'h0A),
    .ANSWER_CYC(32'h10)) u_target_mode_reset_sequencer (.i_sys_clk(clk), .i_rstn(rstn),
    .i_link_sel(link), .i_cmd_valid(valid), .i_cmd_code(code), .i_map_mem(mem),
    .i_map_prop(prop), .i_map_value(val), .i_eeprom_keep_fuse(fuse), .i_tgt_answer(ans),
    .o_busy(busy), .o_done(done), .o_flash_access_mode(mode), .o_tgt_reset_n(rst_n),
    .o_prog_enable(pe), .o_link_active(la), .o_link_clk_en(lce), .o_xfer_req(xfer),
    .o_erase_req(er), .o_erase_eeprom(ee), .o_present(pres), .o_read_data(rd),
    .o_wrong_mode_error(wm), .o_link_failure_error(lf), .o_unsupported_combo_error(uc),
    .o_undetermined_value_error(uv));
  tgt_model u_tgt_model (.i_sys_clk(clk), .i_prog_enable(pe), .i_link_active(la),
    .i_mute(mute), .i_slow(slow), .o_answer(ans));
  // Compares one result and counts it.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // Issues one command strobe and waits for its done pulse.
  task automatic cmd(input logic [1:0] l, input logic [2:0] c, input logic [1:0] m = 2'h0,
    input logic [1:0] p = 2'h0, input logic [31:0] v = 32'h0);
    int n;
    n = 0;
    @(posedge clk);
    link <= l; code <= c; mem <= m; prop <= p; val <= v; valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    chk("done", 32'h1, {31'h0, done});
  endtask
  task automatic t_serial;
    cmd(`LINK_SERIAL, `CMD_SET_PROG);
    chk("reset_n", 32'h0, rst_n);
    chk("prog_en", 32'h1, pe);
    chk("link_err", 32'h0, lf);
    cmd(`LINK_SERIAL, `CMD_ERASE);
    chk("erase_ee", 32'h1, ee);
    cmd(`LINK_SERIAL, `CMD_CLEAR_LAYOUT);
    chk("wrong_mode", 32'h0, wm);
    cmd(`LINK_SERIAL, `CMD_MAP_READ, `MEM_FLASH, `PROP_BASE);
    chk("undetermined", 32'h1, uv);
    // restart harmless here
    // The model holds no firmware, so a brief run during the restart does no harm.
    cmd(`LINK_SERIAL, `CMD_RESTART);
    chk("mode", 32'h1, mode);
    chk("reset_n", 32'h0, rst_n);
    cmd(`LINK_SERIAL, `CMD_SET_RUN);
    chk("reset_n", 32'h1, rst_n);
    chk("prog_en", 32'h0, pe);
    cmd(`LINK_SERIAL, `CMD_ERASE);
    chk("wrong_mode", 32'h1, wm);
    cmd(`LINK_SERIAL, `CMD_CLEAR_LAYOUT);
    chk("wrong_mode", 32'h1, wm);
    cmd(`LINK_SERIAL, `CMD_RESTART);
    chk("mode", 32'h0, mode);
    chk("reset_n", 32'h1, rst_n);
    $display("serial test done");
  endtask
  task automatic t_twowire;
    cmd(`LINK_TWOWIRE, `CMD_SET_PROG);
    chk("reset_n", 32'h1, rst_n);
    chk("link", 32'h1, la);
    cmd(`LINK_TWOWIRE, `CMD_PRESENT);
    chk("present", 32'h1, pres);
    chk("mode", 32'h1, mode);
    @(posedge clk) slow <= 1'b1;
    cmd(`LINK_TWOWIRE, `CMD_RESTART);
    chk("link", 32'h1, la);
    chk("link_err", 32'h0, lf);
    @(posedge clk) slow <= 1'b0;
    cmd(`LINK_TWOWIRE, `CMD_SET_RUN);
    chk("link", 32'h0, la);
    chk("link_clk", 32'h0, lce);
    $display("two-wire test done");
  endtask
  task automatic t_onewire;
    cmd(`LINK_ONEWIRE, `CMD_RESTART);
    chk("unsupported", 32'h1, uc);
    chk("reset_n", 32'h1, rst_n);
    cmd(`LINK_ONEWIRE, `CMD_SET_PROG);
    chk("reset_n", 32'h0, rst_n);
    @(posedge clk) fuse <= 1'b1;
    cmd(`LINK_ONEWIRE, `CMD_ERASE);
    chk("erase_ee", 32'h0, ee);
    @(posedge clk) mute <= 1'b1;
    // Let the synchronised answer fall first, since a standing answer counts at once.
    repeat (8) @(posedge clk);
    cmd(`LINK_ONEWIRE, `CMD_PRESENT);
    chk("present", 32'h0, pres);
    cmd(`LINK_ONEWIRE, `CMD_ERASE);
    chk("link_err", 32'h1, lf);
    @(posedge clk) mute <= 1'b0;
    cmd(`LINK_ONEWIRE, `CMD_SET_RUN);
    chk("prog_en", 32'h0, pe);
    $display("one-wire test done");
  endtask
  task automatic t_map;
    for (int i = 0; i < 3; i++) begin
      cmd(`LINK_SERIAL, `CMD_MAP_WRITE, 2'(i), `PROP_BASE, 32'h0000_1000 + i);
      cmd(`LINK_SERIAL, `CMD_MAP_READ, 2'(i), `PROP_BASE);
      chk("map_read", 32'h0000_1000 + i, rd);
    end
    cmd(`LINK_SERIAL, `CMD_MAP_WRITE, `MEM_RAM, `PROP_PAGE, 32'h0000_0040);
    chk("unsupported", 32'h1, uc);
    cmd(`LINK_SERIAL, `CMD_MAP_READ, `MEM_EEPROM, `PROP_SIZE);
    chk("undetermined", 32'h1, uv);
    $display("map test done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short well after the tests should have ended.
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(negedge clk);
    chk("reset_n", 32'h1, rst_n);
    t_map();
    t_serial();
    t_twowire();
    t_onewire();
    end_of_test();
  end
endmodule
`default_nettype wire
